// [rtl/cfeu_pkg.sv]
package cfeu_pkg;

  localparam logic [4:0] EXC_WATCH = 5'h17;
  localparam logic [4:0] EXC_ADDR_LOAD = 5'h04;
  localparam logic [4:0] EXC_ADDR_STORE = 5'h05;
  localparam logic [4:0] EXC_TLB_LOAD = 5'h02;
  localparam logic [4:0] EXC_TLB_STORE = 5'h03;
  localparam logic [4:0] EXC_IBUS = 5'h06;
  localparam logic [4:0] EXC_DBUS = 5'h07;
  localparam logic [4:0] EXC_NONE = 5'h00;

  localparam logic [31:0] VEC_OFS_REFILL = 32'h0000_0000;
  localparam logic [31:0] VEC_OFS_GENERAL = 32'h0000_0180;
  localparam logic [31:0] VEC_DEBUG = 32'hBFC0_0200;

  localparam int VPN_HI = 31;
  localparam int VPN_LO = 13;
  localparam int KSEG_BIT = 31;

  typedef enum logic [1:0] {
    CFEU_ACC_NONE = 2'b00,
    CFEU_ACC_LOAD = 2'b01,
    CFEU_ACC_STORE = 2'b10
  } cfeu_acc_e;

  typedef enum logic [1:0] {
    CFEU_SZ_BYTE = 2'b00,
    CFEU_SZ_HALF = 2'b01,
    CFEU_SZ_WORD = 2'b10
  } cfeu_sz_e;

  // one memory reference as seen by the exception logic
  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic in_delay_slot;
    logic mapped;
    logic tlb_hit;
    logic tlb_entry_valid;
    logic bounds_fail;
    logic watch_hit;
  } cfeu_ref_s;

  // what is written to the privileged registers on entry
  typedef struct packed {
    logic take;
    logic [4:0] code;
    logic [31:0] vector;
    logic [31:0] return_pc;
    logic bad_vaddr_we;
    logic [31:0] bad_vaddr;
    logic page_we;
    logic [18:0] fault_page;
    logic [7:0] space_tag;
  } cfeu_entry_s;

endpackage : cfeu_pkg

// [rtl/cfeu_unit.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] fetch or data address matching watch registers raises watch exception
// [RULE2] watch taken at once only with exception, error and debug levels zero
// [RULE3] otherwise watch_pending is set and exception waits until all clear
// [RULE4] set watch_pending alone raises watch; handler must clear it
// [RULE5] fetch watch wins over data watch
// [RULE6] watch, address, tlb invalid and bus errors use base plus 0x180
// [RULE7] address error on misaligned word/half or user kernel reference
// [RULE8] misaligned fetch: return pc and faulting_vaddr both hold that address
// [RULE9] address error code: load/fetch one code, store another
// [RULE10] address error loads faulting_vaddr; page and entry fields untouched
// [RULE11] tlb refill on mapped miss with exception_level zero
// [RULE12] refill enters at 0x000 if level was zero, else 0x180
// [RULE13] tlb invalid: miss at level one, entry invalid, or fixed map bound
// [RULE14] tlb faults save vaddr, page bits 31:13 and address space tag
// [RULE15] tlb faults report load code or store code
// [RULE16] fetch or data bus error raises bus error, fetch first
// [RULE17] critical-word errors precise; others taken on external error inputs
// [RULE18] bus error reports instruction or data code
// [RULE19] debug breakpoint instruction sets its flag, return pc, delay bit
// [RULE20] instruction breakpoint match sets its flag, return pc, delay bit
// [RULE21] debug exceptions enter at 0xBFC0_0200
// [RULE22] general exceptions record faulting instruction as return pc
module cfeu_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic exception_level,
  input wire logic error_level,
  input wire logic debug_mode_flag,
  input wire logic user_mode,
  input wire logic fixed_map,
  input wire logic [31:0] exc_base,
  input wire logic [7:0] address_space_tag,
  input wire cfeu_pkg::cfeu_ref_s fetch_ref,
  input wire cfeu_pkg::cfeu_ref_s data_ref,
  input wire cfeu_pkg::cfeu_acc_e data_acc,
  input wire cfeu_pkg::cfeu_sz_e data_size,
  input wire logic [31:0] data_instr_pc,
  input wire logic fetch_bus_err,
  input wire logic data_bus_err,
  input wire logic bus_read_error_in,
  input wire logic bus_write_error_in,
  input wire logic [31:0] bus_err_pc,
  input wire logic bus_err_delay_slot,
  input wire logic debug_breakpoint_instr,
  input wire logic instr_break_match,
  input wire logic [31:0] debug_instr_pc,
  input wire logic debug_instr_in_delay_slot,
  input wire logic watch_pending_clear,
  output cfeu_pkg::cfeu_entry_s entry_q,
  output logic exc_in_delay_slot_q,
  output logic watch_pending_q,
  output logic debug_take_q,
  output logic [31:0] debug_vector_q,
  output logic [31:0] debug_return_pc_q,
  output logic debug_in_delay_slot_q,
  output logic dbg_swbreak_flag_q,
  output logic dbg_instr_break_flag_q
);

  logic rd_err_s1, rd_err_s2, wr_err_s1, wr_err_s2;
  logic blocked;
  logic f_adr, d_adr, f_refill, d_refill, f_inval, d_inval;
  logic d_store;
  logic watch_now, watch_any;
  cfeu_pkg::cfeu_entry_s entry_d;
  logic slot_d;

  // external error strobes come from the bus clock's side of the world
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_err_s1 <= 1'b0;
      rd_err_s2 <= 1'b0;
      wr_err_s1 <= 1'b0;
      wr_err_s2 <= 1'b0;
    end else begin
      rd_err_s1 <= bus_read_error_in;
      rd_err_s2 <= rd_err_s1;
      wr_err_s1 <= bus_write_error_in;
      wr_err_s2 <= wr_err_s1;
    end
  end

  assign blocked = exception_level | error_level | debug_mode_flag;
  assign d_store = (data_acc == cfeu_pkg::CFEU_ACC_STORE);

  always_comb begin
    f_adr = fetch_ref.valid & ((fetch_ref.vaddr[1:0] != 2'b00) |
      (user_mode & fetch_ref.vaddr[cfeu_pkg::KSEG_BIT])); // [RULE7]
    d_adr = data_ref.valid & (data_acc != cfeu_pkg::CFEU_ACC_NONE) & (
      ((data_size == cfeu_pkg::CFEU_SZ_WORD) & (data_ref.vaddr[1:0] != 2'b00))
      | ((data_size == cfeu_pkg::CFEU_SZ_HALF) & data_ref.vaddr[0])
      | (user_mode & data_ref.vaddr[cfeu_pkg::KSEG_BIT])); // [RULE7]
  end

  always_comb begin
    f_refill = fetch_ref.valid & fetch_ref.mapped & ~fixed_map &
      ~fetch_ref.tlb_hit & ~exception_level; // [RULE11]
    d_refill = data_ref.valid & data_ref.mapped & ~fixed_map &
      ~data_ref.tlb_hit & ~exception_level; // [RULE11]
    f_inval = fetch_ref.valid & fetch_ref.mapped & (fixed_map ?
      fetch_ref.bounds_fail : ((~fetch_ref.tlb_hit & exception_level) |
      (fetch_ref.tlb_hit & ~fetch_ref.tlb_entry_valid))); // [RULE13]
    d_inval = data_ref.valid & data_ref.mapped & (fixed_map ?
      data_ref.bounds_fail : ((~data_ref.tlb_hit & exception_level) |
      (data_ref.tlb_hit & ~data_ref.tlb_entry_valid))); // [RULE13]
  end

  assign watch_any = (fetch_ref.valid & fetch_ref.watch_hit) |
    (data_ref.valid & data_ref.watch_hit); // [RULE1]
  assign watch_now = ~blocked & (watch_any | watch_pending_q); // [RULE2] [RULE4]

  // set wins over the handler's clear so no deferred match is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      watch_pending_q <= 1'b0;
    end else if (watch_any & blocked) begin
      watch_pending_q <= 1'b1; // [RULE3]
    end else if (watch_pending_clear) begin
      watch_pending_q <= 1'b0; // [RULE4]
    end
  end

  // priority: fetch side first, then data side, then imprecise bus errors
  always_comb begin
    entry_d = '0;
    slot_d = 1'b0;
    entry_d.vector = exc_base + cfeu_pkg::VEC_OFS_GENERAL; // [RULE6]
    entry_d.space_tag = address_space_tag;
    if (f_adr) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_ADDR_LOAD; // [RULE9]
      entry_d.return_pc = fetch_ref.vaddr; // [RULE8]
      entry_d.bad_vaddr_we = 1'b1;
      entry_d.bad_vaddr = fetch_ref.vaddr; // [RULE8] [RULE10]
      slot_d = fetch_ref.in_delay_slot;
    end else if (f_refill | f_inval) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_TLB_LOAD; // [RULE15]
      if (f_refill) begin
        entry_d.vector = exc_base + cfeu_pkg::VEC_OFS_REFILL; // [RULE12]
      end
      entry_d.return_pc = fetch_ref.vaddr; // [RULE22]
      entry_d.bad_vaddr_we = 1'b1;
      entry_d.bad_vaddr = fetch_ref.vaddr; // [RULE14]
      entry_d.page_we = 1'b1;
      entry_d.fault_page =
        fetch_ref.vaddr[cfeu_pkg::VPN_HI:cfeu_pkg::VPN_LO]; // [RULE14]
      slot_d = fetch_ref.in_delay_slot;
    end else if (fetch_bus_err) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_IBUS; // [RULE16] [RULE18]
      entry_d.return_pc = fetch_ref.vaddr; // [RULE17]
      slot_d = fetch_ref.in_delay_slot;
    end else if (watch_now & fetch_ref.valid & fetch_ref.watch_hit) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_WATCH; // [RULE5]
      entry_d.return_pc = fetch_ref.vaddr;
      slot_d = fetch_ref.in_delay_slot;
    end else if (d_adr) begin
      entry_d.take = 1'b1;
      entry_d.code = d_store ? cfeu_pkg::EXC_ADDR_STORE
        : cfeu_pkg::EXC_ADDR_LOAD; // [RULE9]
      entry_d.return_pc = data_instr_pc; // [RULE22]
      entry_d.bad_vaddr_we = 1'b1;
      entry_d.bad_vaddr = data_ref.vaddr; // [RULE10]
      slot_d = data_ref.in_delay_slot;
    end else if (d_refill | d_inval) begin
      entry_d.take = 1'b1;
      entry_d.code = d_store ? cfeu_pkg::EXC_TLB_STORE
        : cfeu_pkg::EXC_TLB_LOAD; // [RULE15]
      if (d_refill) begin
        entry_d.vector = exc_base + cfeu_pkg::VEC_OFS_REFILL; // [RULE12]
      end
      entry_d.return_pc = data_instr_pc; // [RULE22]
      entry_d.bad_vaddr_we = 1'b1;
      entry_d.bad_vaddr = data_ref.vaddr; // [RULE14]
      entry_d.page_we = 1'b1;
      entry_d.fault_page =
        data_ref.vaddr[cfeu_pkg::VPN_HI:cfeu_pkg::VPN_LO]; // [RULE14]
      slot_d = data_ref.in_delay_slot;
    end else if (data_bus_err) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_DBUS; // [RULE16] [RULE18]
      entry_d.return_pc = data_instr_pc; // [RULE17]
      slot_d = data_ref.in_delay_slot;
    end else if (watch_now) begin
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_WATCH; // [RULE1] [RULE4]
      entry_d.return_pc = data_ref.valid ? data_instr_pc : fetch_ref.vaddr;
      slot_d = data_ref.valid ? data_ref.in_delay_slot
        : fetch_ref.in_delay_slot;
    end else if (rd_err_s2 | wr_err_s2) begin
      // imprecise: blamed on whatever instruction is current
      entry_d.take = 1'b1;
      entry_d.code = cfeu_pkg::EXC_DBUS; // [RULE17]
      entry_d.return_pc = bus_err_pc;
      slot_d = bus_err_delay_slot;
    end
    if (debug_breakpoint_instr | instr_break_match | debug_mode_flag) begin
      entry_d = '0; // debug entry pre-empts general entry this cycle
      entry_d.code = cfeu_pkg::EXC_NONE;
      slot_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      entry_q <= '0;
      exc_in_delay_slot_q <= 1'b0;
    end else begin
      entry_q <= entry_d;
      exc_in_delay_slot_q <= slot_d;
    end
  end

  // debug entry, not taken while already in debug mode
  always_ff @(posedge clk) begin
    if (srst) begin
      debug_take_q <= 1'b0;
      debug_vector_q <= cfeu_pkg::VEC_DEBUG;
      debug_return_pc_q <= 32'h0000_0000;
      debug_in_delay_slot_q <= 1'b0;
      dbg_swbreak_flag_q <= 1'b0;
      dbg_instr_break_flag_q <= 1'b0;
    end else begin
      debug_take_q <= 1'b0;
      debug_vector_q <= cfeu_pkg::VEC_DEBUG; // [RULE21]
      if (~debug_mode_flag &
          (debug_breakpoint_instr | instr_break_match)) begin
        debug_take_q <= 1'b1;
        debug_return_pc_q <= debug_instr_pc; // [RULE19] [RULE20]
        debug_in_delay_slot_q <= debug_instr_in_delay_slot;
        dbg_swbreak_flag_q <= debug_breakpoint_instr; // [RULE19]
        dbg_instr_break_flag_q <= instr_break_match; // [RULE20]
      end
    end
  end

  sequence watch_blocked_s;
    watch_any && blocked && !debug_breakpoint_instr && !instr_break_match;
  endsequence

  watch_defer_a: assert property (@(posedge clk) disable iff (srst)
    watch_blocked_s |=> watch_pending_q && !entry_q.take ||
    entry_q.code != cfeu_pkg::EXC_WATCH) // [RULE3]
    else $error("blocked watch not deferred");

  watch_pend_a: assert property (@(posedge clk) disable iff (srst)
    watch_pending_q && !blocked && !debug_breakpoint_instr &&
    !instr_break_match |=> entry_q.take) // [RULE4]
    else $error("pending watch did not fire");

  refill_vec_a: assert property (@(posedge clk) disable iff (srst)
    f_refill && !f_adr && !debug_breakpoint_instr && !instr_break_match
    && !debug_mode_flag |=>
    entry_q.vector == $past(exc_base) && entry_q.code ==
    cfeu_pkg::EXC_TLB_LOAD) // [RULE12]
    else $error("refill vector wrong");

  tlb_page_a: assert property (@(posedge clk) disable iff (srst)
    entry_q.page_we |-> entry_q.fault_page == entry_q.bad_vaddr[31:13])
    // [RULE14]
    else $error("fault page mismatch");

  fetch_adr_a: assert property (@(posedge clk) disable iff (srst)
    f_adr && !debug_breakpoint_instr && !instr_break_match &&
    !debug_mode_flag |=> entry_q.code == cfeu_pkg::EXC_ADDR_LOAD &&
    entry_q.return_pc == entry_q.bad_vaddr) // [RULE8]
    else $error("misaligned fetch state wrong");

  gen_vec_a: assert property (@(posedge clk) disable iff (srst)
    entry_q.take && !entry_q.page_we |->
    entry_q.vector == $past(exc_base) + cfeu_pkg::VEC_OFS_GENERAL) // [RULE6]
    else $error("general vector wrong");

  dbg_entry_a: assert property (@(posedge clk) disable iff (srst)
    debug_take_q |-> debug_vector_q == cfeu_pkg::VEC_DEBUG &&
    (dbg_swbreak_flag_q || dbg_instr_break_flag_q)) // [RULE21]
    else $error("debug entry wrong");

  bus_prio_a: assert property (@(posedge clk) disable iff (srst)
    fetch_bus_err && data_bus_err && !f_adr && !f_refill && !f_inval &&
    !debug_breakpoint_instr && !instr_break_match && !debug_mode_flag
    |=> entry_q.code == cfeu_pkg::EXC_IBUS) // [RULE16]
    else $error("bus error priority wrong");

  sequence dbg_req_s;
    !debug_mode_flag && (debug_breakpoint_instr || instr_break_match);
  endsequence

  dbg_record_a: assert property (@(posedge clk) disable iff (srst) // [RULE19]
    dbg_req_s |=> debug_take_q &&
    debug_return_pc_q == $past(debug_instr_pc) &&
    debug_in_delay_slot_q == $past(debug_instr_in_delay_slot))
    else $error("debug record wrong");

  dbg_flags_a: assert property (@(posedge clk) disable iff (srst) // [RULE20]
    dbg_req_s |=> dbg_instr_break_flag_q == $past(instr_break_match) &&
    dbg_swbreak_flag_q == $past(debug_breakpoint_instr))
    else $error("debug flags wrong");

  dbg_block_a: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    debug_mode_flag |=> !entry_q.take && !debug_take_q)
    else $error("entry taken in debug mode");

endmodule : cfeu_unit

// [sim/cfeu_far_model.sv]
`timescale 1ns/1ps
// pipeline, translation and bus side of the exception unit
module cfeu_far_model (
  input wire logic clk,
  output cfeu_pkg::cfeu_ref_s fetch_ref,
  output cfeu_pkg::cfeu_ref_s data_ref,
  output cfeu_pkg::cfeu_acc_e data_acc,
  output cfeu_pkg::cfeu_sz_e data_size,
  output logic [31:0] data_instr_pc,
  output logic fetch_bus_err,
  output logic data_bus_err,
  output logic bus_read_error_in,
  output logic bus_write_error_in,
  output logic [31:0] bus_err_pc,
  output logic bus_err_delay_slot
);
  initial begin
    fetch_ref = '0;
    data_ref = '0;
    data_acc = cfeu_pkg::CFEU_ACC_NONE;
    data_size = cfeu_pkg::CFEU_SZ_BYTE;
    data_instr_pc = '0;
    {fetch_bus_err, data_bus_err} = 2'b00;
    {bus_read_error_in, bus_write_error_in} = 2'b00;
    bus_err_pc = '0;
    bus_err_delay_slot = 1'b0;
  end

  // released lines flip so a stale value never passes for a live one
  task automatic idle;
    fetch_ref.valid = 1'b0;
    data_ref.valid = 1'b0;
    fetch_ref.vaddr = ~fetch_ref.vaddr;
    data_ref.vaddr = ~data_ref.vaddr;
    data_instr_pc = ~data_instr_pc;
    data_acc = cfeu_pkg::CFEU_ACC_NONE;
    {fetch_bus_err, data_bus_err} = 2'b00;
  endtask : idle

  task automatic mem_ref(input logic f, input logic [31:0] va,
    input logic [4:0] fl, input cfeu_pkg::cfeu_acc_e a,
    input cfeu_pkg::cfeu_sz_e s, input logic [31:0] pc);
    cfeu_pkg::cfeu_ref_s r;
    r = {1'b1, va, 1'b0, fl};
    if (f) fetch_ref = r;
    else data_ref = r;
    data_acc = a;
    data_size = s;
    data_instr_pc = pc;
  endtask : mem_ref

  task automatic perr(input logic f, input logic d);
    {fetch_bus_err, data_bus_err} = {f, d};
  endtask : perr

  // one-cycle error strobe, blamed pc held afterwards
  task automatic imprecise(input logic wr, input logic [31:0] pc);
    bus_err_pc = pc;
    {bus_write_error_in, bus_read_error_in} = {wr, ~wr};
    @(negedge clk);
    {bus_read_error_in, bus_write_error_in} = 2'b00;
  endtask : imprecise
endmodule : cfeu_far_model

// [sim/test_cfeu_unit.sv]
`timescale 1ns/1ps
module test_cfeu_unit;
  localparam logic [31:0] BASE = 32'h8000_1000;
  localparam logic [31:0] GEN = BASE + cfeu_pkg::VEC_OFS_GENERAL;
  localparam logic [31:0] PC = 32'h0040_0100;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic lvl_exc = 1'b0, lvl_err = 1'b0, lvl_dbg = 1'b0;
  logic user = 1'b0, fmap = 1'b0, sw_bp = 1'b0, hw_bp = 1'b0;
  logic dslot = 1'b0, wclr = 1'b0;
  logic [31:0] dpc = 32'h0;
  cfeu_pkg::cfeu_ref_s fref, dref;
  cfeu_pkg::cfeu_acc_e acc;
  cfeu_pkg::cfeu_sz_e sz;
  logic [31:0] ipc, bpc, dvec, drpc;
  logic fbe, dbe, rbe, wbe, bslot, eslot, wpend, dtake, dds, fsw, fhw;
  cfeu_pkg::cfeu_entry_s ent;
  int err_count = 0;
  int checked = 0;

  always #50 clk = ~clk;

  cfeu_unit i_dut (.clk(clk), .srst(srst), .exception_level(lvl_exc),
    .error_level(lvl_err), .debug_mode_flag(lvl_dbg), .user_mode(user),
    .fixed_map(fmap), .exc_base(BASE), .address_space_tag(8'h5A),
    .fetch_ref(fref), .data_ref(dref), .data_acc(acc), .data_size(sz),
    .data_instr_pc(ipc), .fetch_bus_err(fbe), .data_bus_err(dbe),
    .bus_read_error_in(rbe), .bus_write_error_in(wbe), .bus_err_pc(bpc),
    .bus_err_delay_slot(bslot), .debug_breakpoint_instr(sw_bp),
    .instr_break_match(hw_bp), .debug_instr_pc(dpc),
    .debug_instr_in_delay_slot(dslot), .watch_pending_clear(wclr),
    .entry_q(ent), .exc_in_delay_slot_q(eslot), .watch_pending_q(wpend),
    .debug_take_q(dtake), .debug_vector_q(dvec),
    .debug_return_pc_q(drpc), .debug_in_delay_slot_q(dds),
    .dbg_swbreak_flag_q(fsw), .dbg_instr_break_flag_q(fhw));

  cfeu_far_model i_far (.clk(clk), .fetch_ref(fref), .data_ref(dref),
    .data_acc(acc), .data_size(sz), .data_instr_pc(ipc),
    .fetch_bus_err(fbe), .data_bus_err(dbe), .bus_read_error_in(rbe),
    .bus_write_error_in(wbe), .bus_err_pc(bpc), .bus_err_delay_slot(bslot));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic entry(input logic [4:0] code, input logic [31:0] vec);
    chk(32'(ent.take), 32'h1);
    chk(32'(ent.code), 32'(code));
    chk(ent.vector, vec);
  endtask : entry

  // reference stands one cycle; answer looked at in the next one
  task automatic go(input logic f, input logic [31:0] va,
    input logic [4:0] fl, input cfeu_pkg::cfeu_acc_e a,
    input cfeu_pkg::cfeu_sz_e s);
    @(negedge clk);
    i_far.mem_ref(f, va, fl, a, s, PC);
    @(negedge clk);
    i_far.idle();
  endtask : go

  task automatic t_addr;
    go(1'b1, 32'h0040_0002, 5'h00, cfeu_pkg::CFEU_ACC_NONE,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_ADDR_LOAD, GEN);
    chk(ent.return_pc, 32'h0040_0002);
    chk(ent.bad_vaddr, 32'h0040_0002);
    go(1'b0, 32'h0000_1001, 5'h00, cfeu_pkg::CFEU_ACC_STORE,
      cfeu_pkg::CFEU_SZ_HALF);
    entry(cfeu_pkg::EXC_ADDR_STORE, GEN);
    chk(ent.bad_vaddr, 32'h0000_1001);
    chk(ent.return_pc, PC);
    user = 1'b1;
    go(1'b0, 32'h8000_0000, 5'h00, cfeu_pkg::CFEU_ACC_LOAD,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_ADDR_LOAD, GEN);
    user = 1'b0;
  endtask : t_addr

  task automatic t_tlb;
    go(1'b0, 32'h1234_6000, 5'h10, cfeu_pkg::CFEU_ACC_LOAD,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_TLB_LOAD, BASE);
    chk(32'(ent.fault_page), 32'h0009_1A3);
    chk(32'(ent.space_tag), 32'h5A);
    chk(ent.bad_vaddr, 32'h1234_6000);
    go(1'b1, 32'h1234_6000, 5'h10, cfeu_pkg::CFEU_ACC_NONE,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_TLB_LOAD, BASE);
    chk(ent.return_pc, 32'h1234_6000);
    lvl_exc = 1'b1;
    go(1'b0, 32'h0000_A004, 5'h10, cfeu_pkg::CFEU_ACC_STORE,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_TLB_STORE, GEN);
    lvl_exc = 1'b0;
    go(1'b0, 32'h0000_A004, 5'h18, cfeu_pkg::CFEU_ACC_STORE,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_TLB_STORE, GEN);
    fmap = 1'b1;
    go(1'b0, 32'h0000_A004, 5'h12, cfeu_pkg::CFEU_ACC_LOAD,
      cfeu_pkg::CFEU_SZ_WORD);
    entry(cfeu_pkg::EXC_TLB_LOAD, GEN);
    fmap = 1'b0;
  endtask : t_tlb

  task automatic t_bus;
    @(negedge clk);
    i_far.perr(1'b1, 1'b1);
    @(negedge clk);
    i_far.idle();
    entry(cfeu_pkg::EXC_IBUS, GEN);
    @(negedge clk);
    i_far.perr(1'b0, 1'b1);
    @(negedge clk);
    i_far.idle();
    entry(cfeu_pkg::EXC_DBUS, GEN);
    for (int w = 0; w < 2; w++) begin
      @(negedge clk);
      i_far.imprecise(w[0], 32'h0040_0300 + w);
      repeat (2) @(negedge clk);
      entry(cfeu_pkg::EXC_DBUS, GEN);
      chk(ent.return_pc, 32'h0040_0300 + w);
    end
  endtask : t_bus

  task automatic t_watch;
    @(negedge clk);
    i_far.mem_ref(1'b1, 32'h0040_0010, 5'h01, cfeu_pkg::CFEU_ACC_NONE,
      cfeu_pkg::CFEU_SZ_WORD, PC);
    i_far.mem_ref(1'b0, 32'h0000_3000, 5'h01, cfeu_pkg::CFEU_ACC_LOAD,
      cfeu_pkg::CFEU_SZ_WORD, PC);
    @(negedge clk);
    i_far.idle();
    entry(cfeu_pkg::EXC_WATCH, GEN);
    chk(ent.return_pc, 32'h0040_0010);
    lvl_err = 1'b1;
    go(1'b0, 32'h0000_3000, 5'h01, cfeu_pkg::CFEU_ACC_LOAD,
      cfeu_pkg::CFEU_SZ_WORD);
    chk(32'(ent.take), 32'h0);
    chk(32'(wpend), 32'h1);
    @(negedge clk);
    chk(32'(ent.take), 32'h0);
    lvl_err = 1'b0;
    @(negedge clk);
    entry(cfeu_pkg::EXC_WATCH, GEN);
    wclr = 1'b1;
    @(negedge clk);
    wclr = 1'b0;
    @(negedge clk);
    chk(32'(wpend), 32'h0);
    chk(32'(ent.take), 32'h0);
  endtask : t_watch

  task automatic t_debug;
    @(negedge clk);
    {sw_bp, dslot, dpc} = {2'b11, 32'h0040_0400};
    @(negedge clk);
    sw_bp = 1'b0;
    chk(32'({dtake, fsw, dds}), 32'h7);
    chk(drpc, 32'h0040_0400);
    chk(dvec, cfeu_pkg::VEC_DEBUG);
    {hw_bp, dslot, dpc} = {2'b10, 32'h0040_0404};
    @(negedge clk);
    hw_bp = 1'b0;
    chk(32'({dtake, fhw, dds}), 32'h6);
    chk(drpc, 32'h0040_0404);
  endtask : t_debug

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    chk(dvec, cfeu_pkg::VEC_DEBUG);
    t_addr();
    t_tlb();
    t_bus();
    t_watch();
    t_debug();
    results();
  end

  // the scenarios need well under 200 cycles
  initial begin
    #(1000 * 100);
    err_count++;
    results();
  end
endmodule : test_cfeu_unit
